// file: src/rpf_consts.vh
/*
  Constants for the root port feature block: routing-ID field layout,
  access-control decisions, training symbol codes and timing counts.
  Assumes inclusion by bare name from the design files under src/.
*/
// Operation
// RULE1: Routing ID may use an eight-bit function number beyond eight functions.
// RULE2: Access control checks traffic between endpoints and between functions.
// RULE3: Each controlled TLP is forwarded, blocked or redirected by control points.
// RULE4: Each receiver lane detects and fixes swapped polarity on its own.
// RULE5: Polarity correction is applied during the lane's initial training.
// RULE6: Polarity correction is automatic with no configuration enable.
// RULE7: Polarity fix never reverses lane order or transmit/receive direction.
// RULE8: Time measurement uses transaction-layer message requests both ways.
// RULE9: Each port has its own independent time measurement enable.
// RULE10: Link-failure debug output asserts on a detected link-down event.
`ifndef RPF_CONSTS_VH
`define RPF_CONSTS_VH

// Routing ID layout: bus[15:8], then device[7:3]/function[2:0] or ARI fn[7:0].
`define RPF_RID_BUS_MSB  15
`define RPF_RID_BUS_LSB  8
`define RPF_RID_DEV_MSB  7
`define RPF_RID_DEV_LSB  3
`define RPF_RID_FN_MSB   2

// Access-control decision codes.
`define RPF_ACT_ROUTE    2'h0
`define RPF_ACT_BLOCK    2'h1
`define RPF_ACT_REDIR    2'h2

// Training symbol as received upright and with swapped wiring.
`define RPF_TS_SYM       8'h4a
`define RPF_TS_SYM_INV   8'hb5

// Symbols in a row that must match before the lane is declared trained.
`define RPF_TS_NEED      4'h8

// Minimum link-down debug pulse and the core clock period, in nanoseconds.
`define RPF_LDN_NS       1000
`define RPF_CLK_NS       25

// PTM message codes carried in the message-request code field.
`define RPF_MSG_PTM_REQ  8'h52
`define RPF_MSG_PTM_RSP  8'h53
`define RPF_MSG_PTM_RSPD 8'h53

`endif

// file: src/rpf_lane_pol.v
/*
  Per-lane receiver polarity detector and corrector.
  Assumes 8-bit parallel symbols from a deserialiser on core_clk, and a
  training flag from the link state logic on the same clock.
*/
`timescale 1ns/1ps
`include "rpf_consts.vh"

module rpf_lane_pol (
  input  wire       core_clk,
  input  wire       rst_n,
  input  wire       train,
  input  wire       sym_vld,
  input  wire [7:0] sym_in,
  output reg  [7:0] sym_out,
  output reg        sym_out_vld,
  output reg        inv_q,
  output reg        locked_q
);

  reg [3:0] run_q;
  wire      up_hit  = (sym_in == `RPF_TS_SYM);
  wire      inv_hit = (sym_in == `RPF_TS_SYM_INV);

  // The decision is frozen once locked so noise after training cannot flip
  // a good lane; only reset clears the lock, a new training pass does not.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      inv_q       <= 1'b0;
      locked_q    <= 1'b0;
      run_q       <= 4'h0;
      sym_out     <= 8'h00;
      sym_out_vld <= 1'b0;
    end else begin
      sym_out_vld <= sym_vld;
      if (sym_vld)
        sym_out <= inv_q ? ~sym_in : sym_in; // RULE4
      if (!train) begin
        run_q <= 4'h0;
      end else if (!locked_q && sym_vld) begin // RULE5
        if (up_hit || inv_hit) begin
          if (inv_hit != inv_q) begin
            inv_q <= inv_hit; // RULE6
            run_q <= 4'h1;
          end else if (run_q == `RPF_TS_NEED - 4'h1) begin
            locked_q <= 1'b1;
          end else begin
            run_q <= run_q + 4'h1;
          end
        end else begin
          run_q <= 4'h0;
        end
      end
      if (train && !locked_q && !sym_vld)
        locked_q <= locked_q;
      if (!train && locked_q && !sym_vld)
        locked_q <= locked_q;
    end
  end

endmodule // rpf_lane_pol

// file: src/rpf_root_port.v
/*
  Root port feature logic: routing-ID interpretation, access-control
  decisions, per-lane polarity correction, PTM message steering and the
  link-down debug output.
  Assumes a TLP header presented as a one-cycle valid strobe, lane symbols
  already aligned to core_clk, and link state from the same clock domain.
  Configuration inputs are static straps from the port's config space.
*/
`timescale 1ns/1ps
`include "rpf_consts.vh"

module rpf_root_port #(
  parameter LANES  = 4,
  parameter LDN_NS = `RPF_LDN_NS
) (
  input  wire               core_clk,
  input  wire               rst_n,
  input  wire               ari_en,
  input  wire               acs_en,
  input  wire               acs_redir_en,
  input  wire               acs_p2p_block,
  input  wire [7:0]         sec_bus,
  input  wire               ptm_en,
  input  wire               tlp_vld,
  input  wire [15:0]        tlp_req_id,
  input  wire [15:0]        tlp_dst_id,
  input  wire               tlp_is_msg,
  input  wire [7:0]         tlp_msg_code,
  input  wire               train,
  input  wire [LANES-1:0]   sym_vld,
  input  wire [LANES*8-1:0] sym_in,
  input  wire               link_up,
  input  wire               l1ss_exit,
  output reg                dec_vld_q,
  output reg  [1:0]         dec_act_q,
  output reg  [7:0]         dst_fn_q,
  output reg  [4:0]         dst_dev_q,
  output reg                ptm_msg_q,
  output reg  [LANES*8-1:0] sym_out_q,
  output reg  [LANES-1:0]   sym_out_vld_q,
  output reg  [LANES-1:0]   lane_inv_q,
  output reg  [LANES-1:0]   lane_lock_q,
  output reg                link_down_q
);

  localparam integer LDN_CYC_I =
    ((LDN_NS + `RPF_CLK_NS - 1) / `RPF_CLK_NS) < 1 ? 1 :
    (LDN_NS + `RPF_CLK_NS - 1) / `RPF_CLK_NS;
  localparam [15:0]  LDN_CYC   = LDN_CYC_I[15:0];

  // Routing-ID decode. With ARI the device field is folded into an eight-bit
  // function number, so a device below the port may expose up to 256.
  wire [7:0] dst_bus = tlp_dst_id[`RPF_RID_BUS_MSB:`RPF_RID_BUS_LSB];
  wire [7:0] req_bus = tlp_req_id[`RPF_RID_BUS_MSB:`RPF_RID_BUS_LSB];
  wire [7:0] dst_fn  = ari_en ? tlp_dst_id[`RPF_RID_DEV_MSB:0] // RULE1
                              : {5'h00, tlp_dst_id[`RPF_RID_FN_MSB:0]};
  wire [4:0] dst_dev = ari_en ? 5'h00
                       : tlp_dst_id[`RPF_RID_DEV_MSB:`RPF_RID_DEV_LSB];

  // Peer traffic: both ends below this port but a different function or
  // endpoint; that includes two functions of one multi-function device.
  wire peer = (dst_bus == sec_bus) && (req_bus == sec_bus) &&
              (tlp_dst_id != tlp_req_id); // RULE2

  wire is_ptm = tlp_is_msg && ((tlp_msg_code == `RPF_MSG_PTM_REQ) ||
                               (tlp_msg_code == `RPF_MSG_PTM_RSP));

  reg [1:0] act_d;
  always @* begin
    act_d = `RPF_ACT_ROUTE;
    if (acs_en && peer) begin // RULE3
      if (acs_redir_en)
        act_d = `RPF_ACT_REDIR;
      else if (acs_p2p_block)
        act_d = `RPF_ACT_BLOCK;
    end
    // PTM messages are dropped while this port's enable is off.
    if (is_ptm && !ptm_en) // RULE9
      act_d = `RPF_ACT_BLOCK;
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dec_vld_q <= 1'b0;
      dec_act_q <= `RPF_ACT_ROUTE;
      dst_fn_q  <= 8'h00;
      dst_dev_q <= 5'h00;
      ptm_msg_q <= 1'b0;
    end else begin
      dec_vld_q <= tlp_vld;
      if (tlp_vld) begin
        dec_act_q <= act_d;
        dst_fn_q  <= dst_fn;
        dst_dev_q <= dst_dev;
        ptm_msg_q <= is_ptm && ptm_en; // RULE8
      end
    end
  end

  // Each lane has its own detector; lane index is kept as wired so lane
  // order and direction are never touched by the correction.
  wire [LANES*8-1:0] lp_sym;
  wire [LANES-1:0]   lp_vld;
  wire [LANES-1:0]   lp_inv;
  wire [LANES-1:0]   lp_lock;
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : g_lane
      rpf_lane_pol u_pol (
        .core_clk    (core_clk),
        .rst_n       (rst_n),
        .train       (train),
        .sym_vld     (sym_vld[g]),
        .sym_in      (sym_in[g*8 +: 8]), // RULE7
        .sym_out     (lp_sym[g*8 +: 8]),
        .sym_out_vld (lp_vld[g]),
        .inv_q       (lp_inv[g]),
        .locked_q    (lp_lock[g])
      );
    end
  endgenerate

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sym_out_q     <= {LANES*8{1'b0}};
      sym_out_vld_q <= {LANES{1'b0}};
      lane_inv_q    <= {LANES{1'b0}};
      lane_lock_q   <= {LANES{1'b0}};
    end else begin
      sym_out_q     <= lp_sym; // RULE4
      sym_out_vld_q <= lp_vld;
      lane_inv_q    <= lp_inv;
      lane_lock_q   <= lp_lock;
    end
  end

  // Link-down: a fall of link_up, or an L1 sub-state exit that does not
  // bring the link back up. The output is stretched so a slow debug pin
  // sampler cannot miss a one-cycle event.
  reg        up_q;
  reg        l1_wait_q;
  reg [15:0] ldn_cnt_q;
  wire       ldn_evt = (up_q && !link_up) || (l1_wait_q && !train &&
                                               !link_up);
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      up_q        <= 1'b0;
      l1_wait_q   <= 1'b0;
      ldn_cnt_q   <= 16'h0000;
      link_down_q <= 1'b0;
    end else begin
      up_q <= link_up;
      if (l1ss_exit)
        l1_wait_q <= 1'b1;
      else if (link_up || ldn_evt)
        l1_wait_q <= 1'b0;
      if (ldn_evt) begin // RULE10
        ldn_cnt_q   <= LDN_CYC;
        link_down_q <= 1'b1;
      end else if (ldn_cnt_q > 16'h0001) begin
        ldn_cnt_q   <= ldn_cnt_q - 16'h0001;
      end else begin
        ldn_cnt_q   <= 16'h0000;
        link_down_q <= 1'b0;
      end
    end
  end

endmodule // rpf_root_port

// file: sim/rpf_root_port_monitor.sv
/* Checker bound to the root port feature block ports.
   Assumes one clock domain and the active-low async reset. */
`timescale 1ns/1ps
`include "rpf_consts.vh"
module rpf_root_port_monitor #(
  parameter LANES = 4
) (
  input wire             core_clk, rst_n, ari_en, acs_en, acs_redir_en,
  input wire             acs_p2p_block, ptm_en, tlp_vld, tlp_is_msg,
  input wire             link_up, dec_vld_q, ptm_msg_q, link_down_q,
  input wire [7:0]       sec_bus, tlp_msg_code, dst_fn_q,
  input wire [15:0]      tlp_req_id, tlp_dst_id,
  input wire [LANES-1:0] sym_vld, sym_out_vld_q, lane_lock_q,
  input wire [1:0]       dec_act_q,
  input wire [4:0]       dst_dev_q
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire       ptm_m = tlp_is_msg && (tlp_msg_code == `RPF_MSG_PTM_REQ ||
                     tlp_msg_code == `RPF_MSG_PTM_RSP);
  wire       peer = tlp_req_id[15:8] == sec_bus &&
                    tlp_dst_id[15:8] == sec_bus && tlp_req_id != tlp_dst_id;
  wire [1:0] act_w = ptm_m && !ptm_en ? `RPF_ACT_BLOCK :
                     !(acs_en && peer) ? `RPF_ACT_ROUTE :
                     acs_redir_en ? `RPF_ACT_REDIR :
                     acs_p2p_block ? `RPF_ACT_BLOCK : `RPF_ACT_ROUTE;
  sequence s_tlp; tlp_vld; endsequence
  sequence s_ldn; ##[0:1] link_down_q; endsequence
  a_dec_pulse: assert property (s_tlp |=> dec_vld_q)
    else $error("decision strobe missing");
  a_dec_quiet: assert property (!tlp_vld |=> !dec_vld_q)
    else $error("decision strobe without tlp");
  a_ari_fn: assert property (s_tlp and ari_en |=> dst_dev_q == 5'h0 &&
    dst_fn_q == $past(tlp_dst_id[7:0])) else $error("wide function wrong");
  a_std_fn: assert property (s_tlp and !ari_en |=> {dst_dev_q, dst_fn_q} ==
    {$past(tlp_dst_id[7:3]), 5'h0, $past(tlp_dst_id[2:0])})
    else $error("device or function wrong");
  a_acs_act: assert property (s_tlp |=> dec_act_q == $past(act_w))
    else $error("action wrong");
  a_ptm_flag: assert property (s_tlp |=> ptm_msg_q == $past(ptm_m && ptm_en))
    else $error("time message flag wrong");
  a_sym_lat: assert property (sym_vld[0] |-> ##2 sym_out_vld_q[0])
    else $error("lane output strobe late");
  a_lock_hold: assert property (lane_lock_q[0] |=> lane_lock_q[0])
    else $error("lane lock dropped");
  a_ldn_rise: assert property ($fell(link_up) |=> s_ldn)
    else $error("link down output missing");
endmodule // rpf_root_port_monitor

// file: sim/rpf_ep_model.sv
/* Endpoint lane source: one symbol per lane per cycle.
   Assumes the bench picks which lanes have their pair swapped. */
`timescale 1ns/1ps
module rpf_ep_model (
  input  wire        core_clk,
  input  wire        on,
  input  wire [3:0]  inv,
  input  wire [7:0]  sym,
  output reg  [3:0]  sym_vld,
  output reg  [31:0] sym_in
);
  integer g;
  initial begin
    sym_vld = 4'h0;
    sym_in = 32'h0;
  end
  // Lane g always feeds lane g; idle data toggles so it never looks valid.
  always @(negedge core_clk) begin
    sym_vld <= {4{on}};
    for (g = 0; g < 4; g = g + 1)
      sym_in[g*8+:8] <= !on ? ~sym_in[g*8+:8] : inv[g] ? ~sym : sym;
  end
endmodule // rpf_ep_model

// file: sim/tb_pcie_root_port_link_features.sv
/* Bench for the root port feature block: lanes, TLP decisions, link down.
   Assumes the lane source model and the checker are compiled first. */
`timescale 1ns/1ps
`include "rpf_consts.vh"
module tb_pcie_root_port_link_features;
  reg         core_clk = 1'b0, rst_n = 1'b0, ari_en = 1'b0, acs_en = 1'b0;
  reg         acs_redir_en = 1'b0, acs_p2p_block = 1'b0, ptm_en = 1'b0;
  reg         tlp_vld = 1'b0, tlp_is_msg = 1'b0, train = 1'b0, ep_on = 1'b0;
  reg         link_up = 1'b0, l1ss_exit = 1'b0;
  reg  [3:0]  ep_inv = 4'h0;
  reg  [7:0]  sec_bus = 8'h3, tlp_msg_code = 8'h0, ep_sym = 8'h0;
  reg  [15:0] tlp_req_id = 16'h0, tlp_dst_id = 16'h0, ev = 16'h0;
  wire [3:0]  sym_vld, sym_out_vld_q, lane_inv_q, lane_lock_q;
  wire [31:0] sym_in, sym_out_q;
  wire [1:0]  dec_act_q;
  wire [7:0]  dst_fn_q;
  wire [4:0]  dst_dev_q;
  wire        dec_vld_q, ptm_msg_q, link_down_q;
  integer     failures = 0, checks_done = 0, i, n;
  always #12.5 core_clk = ~core_clk;
  rpf_root_port #(.LANES(4), .LDN_NS(50)) i_dut (.core_clk, .rst_n, .ari_en,
    .acs_en, .acs_redir_en, .acs_p2p_block, .sec_bus, .ptm_en, .tlp_vld,
    .tlp_req_id, .tlp_dst_id, .tlp_is_msg, .tlp_msg_code, .train, .sym_vld,
    .sym_in, .link_up, .l1ss_exit, .dec_vld_q, .dec_act_q, .dst_fn_q,
    .dst_dev_q, .ptm_msg_q, .sym_out_q, .sym_out_vld_q, .lane_inv_q,
    .lane_lock_q, .link_down_q);
  rpf_ep_model i_ep (.core_clk, .on(ep_on), .inv(ep_inv), .sym(ep_sym),
    .sym_vld, .sym_in);
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task summarize;
    begin
      if (failures == 0 && checks_done > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // Packs {time flag, action, device, function} as the port shows them.
  function [15:0] exp_f(input [15:0] r, input [15:0] d);
    reg       pm;
    reg [1:0] a;
    begin
      pm = tlp_is_msg && (tlp_msg_code == `RPF_MSG_PTM_REQ ||
           tlp_msg_code == `RPF_MSG_PTM_RSP);
      a = 2'h0;
      if (acs_en && r[15:8] == sec_bus && d[15:8] == sec_bus && r != d)
        a = acs_redir_en ? 2'h2 : {1'b0, acs_p2p_block};
      if (pm && !ptm_en)
        a = 2'h1;
      exp_f = {pm && ptm_en, a,
               ari_en ? {5'h0, d[7:0]} : {d[7:3], 5'h0, d[2:0]}};
    end
  endfunction
  initial begin
    #20000;
    failures = failures + 1;
    summarize;
  end
  initial begin
    void'($urandom(32'h9fc2));
    repeat (3) @(negedge core_clk);
    {rst_n, link_up, train, ep_on, ep_inv, ep_sym} = {4'hf, 4'h5, 8'h4a};
    repeat (14) @(negedge core_clk);
    chk(lane_inv_q, 4'h5);
    chk(lane_lock_q, 4'hf);
    {train, ep_sym} = {1'b0, 8'h3c};
    repeat (4) @(negedge core_clk);
    chk(sym_out_q, {4{8'h3c}});
    ep_on = 1'b0;
    for (i = 0; i <= 40; i = i + 1) begin
      @(negedge core_clk);
      if (i > 0) begin
        chk(dec_vld_q, 1'b1);
        chk({ptm_msg_q, dec_act_q, dst_dev_q, dst_fn_q}, ev);
      end
      {ari_en, acs_en, acs_redir_en, acs_p2p_block, ptm_en} =
        i < 4 ? {2'b11, i[1:0], 1'b0} : 5'($urandom);
      tlp_req_id = {8'h3 ^ 8'($urandom % 2), 8'($urandom)};
      tlp_dst_id = {8'h3, 8'($urandom)};
      tlp_is_msg = 1'($urandom);
      tlp_msg_code = 8'h52 + 8'($urandom % 3);
      ev = exp_f(tlp_req_id, tlp_dst_id);
      tlp_vld = i < 40;
    end
    for (i = 0; i < 2; i = i + 1) begin
      repeat (6) @(negedge core_clk);
      chk(link_down_q, 1'b0);
      {link_up, l1ss_exit} = {1'b0, i[0]};
      @(negedge core_clk);
      l1ss_exit = 1'b0;
      for (n = 0; n < 3 && link_down_q !== 1'b1; n = n + 1)
        @(negedge core_clk);
      chk(link_down_q, 1'b1);
      // With a 50 ns stretch the output stands for exactly two cycles.
      @(negedge core_clk);
      chk(link_down_q, 1'b1);
      @(negedge core_clk);
      chk(link_down_q, 1'b0);
    end
    summarize;
  end
endmodule // tb_pcie_root_port_link_features
bind rpf_root_port rpf_root_port_monitor #(.LANES(LANES)) i_mon (.core_clk,
  .rst_n, .ari_en, .acs_en, .acs_redir_en, .acs_p2p_block, .ptm_en,
  .tlp_vld, .tlp_is_msg, .link_up, .dec_vld_q, .ptm_msg_q, .link_down_q,
  .sec_bus, .tlp_msg_code, .dst_fn_q, .tlp_req_id, .tlp_dst_id, .sym_vld,
  .sym_out_vld_q, .lane_lock_q, .dec_act_q, .dst_dev_q);
